/* File: src/crcs_pkg.sv */
// Purpose: shared constants and types for the checksum engine with memory scanner
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: register offsets are byte addresses
package crcs_pkg;
   localparam logic [7:0] OFF_CONTROL_0 = 8'h00;
   localparam logic [7:0] OFF_CONTROL_1 = 8'h04;
   localparam logic [7:0] OFF_INPUT_WORD = 8'h08;
   localparam logic [7:0] OFF_ACCUMULATOR = 8'h0C;
   localparam logic [7:0] OFF_POLYNOMIAL = 8'h10;
   localparam logic [7:0] OFF_SCAN_CONTROL = 8'h14;
   localparam logic [7:0] OFF_SCAN_START = 8'h18;
   localparam logic [7:0] OFF_SCAN_END = 8'h1C;
   localparam logic [7:0] OFF_SCAN_TRIGGER = 8'h20;
   localparam logic [7:0] OFF_FLAGS = 8'h24;
   // control 0 fields
   localparam int C0_ENABLE = 7;
   localparam int C0_RUN = 6;
   localparam int C0_BUSY = 5;
   localparam int C0_AUGMENT = 4;
   localparam int C0_LSB_FIRST = 1;
   localparam int C0_FULL = 0;
   // control 1 fields
   localparam int C1_DATA_LSB = 0;
   localparam int C1_POLY_LSB = 4;
   // scanner control fields
   localparam int SC_RUN = 7;
   localparam int SC_PRIO = 4;
   localparam int SC_MODE_LSB = 0;
   // flag register fields, done bits write one to clear
   localparam int FL_CRC_DONE = 0;
   localparam int FL_SCAN_DONE = 1;
   localparam int FL_CRC_IE = 8;
   localparam int FL_SCAN_IE = 9;
   localparam logic [15:0] RESET_WORD16 = 16'h0000;
   localparam logic [3:0] RESET_NIBBLE = 4'h0;
   localparam int ADDR_W = 15;
   localparam int TRIG_W = 4;
   typedef enum logic [1:0] {
      MODE_CONCURRENT = 2'b00,
      MODE_BURST = 2'b01,
      MODE_PEEK = 2'b10,
      MODE_TRIGGERED = 2'b11
   } crcs_mode_t;
   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_DATA = 2'b01,
      ENG_ZERO = 2'b10
   } crcs_eng_t;
   typedef enum logic [1:0] {
      SCN_IDLE = 2'b00,
      SCN_WAIT = 2'b01,
      SCN_READ = 2'b10
   } crcs_scan_t;
   // memory fetch request and answer
   typedef struct packed {
      logic req;
      logic [ADDR_W-1:0] addr;
   } crcs_mem_req_t;
   typedef struct packed {
      logic valid;
      logic implemented;
      logic [15:0] data;
   } crcs_mem_rsp_t;
endpackage

/* File: src/crcs_top.sv */
// Purpose: checksum shift engine plus program memory scanner, APB registers
// Assumes: memory answers a fetch request some cycles later with one valid pulse
// Notes: one data bit shifted per clock; cpu stall outputs are levels
`timescale 1ns/100ps
`default_nettype none
module crcs_top
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output crcs_pkg::crcs_mem_req_t memReq,
   input wire crcs_pkg::crcs_mem_rsp_t memRsp,
   input wire logic cpuNeedsMemory,
   input wire logic [15:0] triggerSources,
   output logic cpuStall,
   output logic crcDoneIrq,
   output logic scanDoneIrq
);
   import crcs_pkg::*;

   logic enable, checksumRun, augment, lsbFirst;
   logic [3:0] dataWidthM1, polyWidthM2;
   logic [15:0] inputWord, accumulator, polynomial, shiftReg;
   logic scanRun, scanPrio;
   crcs_mode_t scanMode;
   logic [ADDR_W-1:0] scanStart, scanEnd, scanAddr;
   logic [TRIG_W-1:0] trigSelect;
   logic crcDone, scanDone, checksum_done_irq_enable, scan_done_irq_enable;
   logic full, busyPrev;
   crcs_eng_t engState;
   crcs_scan_t scanState;
   logic [4:0] bitCount;
   logic [2:0] trigSync;
   logic trigLevel, trigPrev;
   logic scanLoad, scanFinish, lastWord;

   wire logic wrAcc = psel && penable && pwrite;
   // read data registered in setup so it stands at the access edge
   wire logic rdAcc = psel && !penable && !pwrite;
   wire logic busy = full || (engState != ENG_IDLE);

   // byte-lane merge for apb writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   // offset decode, used for write paths; reads decode in the read mux case
   function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // zero-wait slave
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // control 0 and 1 registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         enable <= 1'b0;
         checksumRun <= 1'b0;
         augment <= 1'b0;
         lsbFirst <= 1'b0;
         dataWidthM1 <= RESET_NIBBLE;
         polyWidthM2 <= RESET_NIBBLE;
      end
      else if (wrAcc && isReg(paddr, OFF_CONTROL_0) && pstrb[0])
      begin
         enable <= pwdata[C0_ENABLE];
         checksumRun <= pwdata[C0_RUN];
         augment <= pwdata[C0_AUGMENT];
         lsbFirst <= pwdata[C0_LSB_FIRST];
      end
      else if (wrAcc && isReg(paddr, OFF_CONTROL_1) && pstrb[0])
      begin
         dataWidthM1 <= pwdata[C1_DATA_LSB +: 4];
         polyWidthM2 <= pwdata[C1_POLY_LSB +: 4];
      end
   end

   // polynomial register, bit zero reads back as zero
   always_ff @(posedge clk)
   begin
      if (reset)
         polynomial <= RESET_WORD16;
      else if (wrAcc && isReg(paddr, OFF_POLYNOMIAL))
         polynomial <= 16'(merge({16'h0000, polynomial}, pwdata, pstrb)) & 16'hFFFE;
   end

   // input word: high byte just stored, low byte write starts a word
   always_ff @(posedge clk)
   begin
      if (reset)
         inputWord <= RESET_WORD16;
      else if (scanLoad)
         inputWord <= memRsp.data;
      else if (wrAcc && isReg(paddr, OFF_INPUT_WORD))
         inputWord <= 16'(merge({16'h0000, inputWord}, pwdata, pstrb));
   end

   // low byte write marks pending word, scanner loads too
   always_ff @(posedge clk)
   begin
      if (reset || !enable)
         full <= 1'b0;
      else if (scanLoad || (wrAcc && isReg(paddr, OFF_INPUT_WORD) && pstrb[0]))
         full <= 1'b1;
      else if (engState == ENG_IDLE && checksumRun)
         full <= 1'b0;
   end

   // shift engine; one bit per clock (feedback per selected poly width)
   always_ff @(posedge clk)
   begin
      logic inBit, fb;
      logic [15:0] polyEff, next_acc;
      inBit = 1'b0;
      fb = 1'b0;
      // bottom bit always one, top term implied by feedback
      polyEff = polynomial | 16'h0001;
      next_acc = accumulator;
      if (reset)
      begin
         accumulator <= RESET_WORD16;
         shiftReg <= RESET_WORD16;
         bitCount <= 5'h00;
         engState <= ENG_IDLE;
      end
      else if (!enable)
      begin
         engState <= ENG_IDLE;
         bitCount <= 5'h00;
         if (wrAcc && isReg(paddr, OFF_ACCUMULATOR))
            accumulator <= 16'(merge({16'h0000, accumulator}, pwdata, pstrb));
      end
      else if (wrAcc && isReg(paddr, OFF_ACCUMULATOR))
         accumulator <= 16'(merge({16'h0000, accumulator}, pwdata, pstrb));
      else
      begin
         unique case (engState)
            ENG_IDLE:
            begin
               if (full && checksumRun)
               begin
                  shiftReg <= inputWord & 16'((17'h00002 << dataWidthM1) - 17'h00001);
                  bitCount <= {1'b0, dataWidthM1};
                  engState <= ENG_DATA;
               end
            end
            ENG_DATA, ENG_ZERO:
            begin
               if (checksumRun)
               begin
                  // msb at data width, or lsb first
                  if (engState == ENG_ZERO)
                     inBit = 1'b0;
                  else if (lsbFirst)
                     inBit = shiftReg[0];
                  else
                     inBit = shiftReg[dataWidthM1];
                  // feedback from top bit of active width
                  fb = accumulator[polyWidthM2 + 4'h1];
                  next_acc = {accumulator[14:0], inBit};
                  if (fb)
                     next_acc = next_acc ^ polyEff;
                  accumulator <= next_acc & 16'((17'h00002 << (polyWidthM2 + 4'h1)) - 17'h00001);
                  shiftReg <= lsbFirst ? {1'b0, shiftReg[15:1]} : {shiftReg[14:0], 1'b0};
                  bitCount <= bitCount - 5'h01;
                  // shifts per word set by width field
                  if (bitCount == 5'h00)
                  begin
                     if (engState == ENG_DATA && augment && !full && !scanRun)
                     begin
                        engState <= ENG_ZERO;
                        bitCount <= 5'(polyWidthM2) + 5'h01;
                     end
                     else
                        engState <= ENG_IDLE;
                  end
               end
            end
            default:
               engState <= ENG_IDLE;
         endcase
      end
   end

   // busy falling sets done, set wins over clear
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         busyPrev <= 1'b0;
         crcDone <= 1'b0;
         scanDone <= 1'b0;
      end
      else
      begin
         busyPrev <= busy;
         if (busyPrev && !busy)
            crcDone <= 1'b1;
         else if (wrAcc && isReg(paddr, OFF_FLAGS) && pstrb[0] && pwdata[FL_CRC_DONE])
            crcDone <= 1'b0;
         if (scanFinish)
            scanDone <= 1'b1;
         else if (wrAcc && isReg(paddr, OFF_FLAGS) && pstrb[0] && pwdata[FL_SCAN_DONE])
            scanDone <= 1'b0;
      end
   end

   // interrupt enables
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         checksum_done_irq_enable <= 1'b0;
         scan_done_irq_enable <= 1'b0;
      end
      else if (wrAcc && isReg(paddr, OFF_FLAGS) && pstrb[1])
      begin
         checksum_done_irq_enable <= pwdata[FL_CRC_IE];
         scan_done_irq_enable <= pwdata[FL_SCAN_IE];
      end
   end

   // scanner configuration registers, untouched by disable
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         scanMode <= MODE_CONCURRENT;
         scanPrio <= 1'b0;
         scanEnd <= '0;
         trigSelect <= '0;
      end
      else if (wrAcc)
      begin
         if (isReg(paddr, OFF_SCAN_CONTROL) && pstrb[0])
         begin
            scanMode <= crcs_mode_t'(pwdata[SC_MODE_LSB +: 2]);
            scanPrio <= pwdata[SC_PRIO];
         end
         if (isReg(paddr, OFF_SCAN_END))
            scanEnd <= ADDR_W'(merge({17'h00000, scanEnd}, pwdata, pstrb));
         if (isReg(paddr, OFF_SCAN_TRIGGER) && pstrb[0])
            trigSelect <= pwdata[TRIG_W-1:0];
      end
   end

   // trigger input from another domain: three flops, second and third agree
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trigSync <= 3'b000;
         trigLevel <= 1'b0;
         trigPrev <= 1'b0;
      end
      else
      begin
         trigSync <= {trigSync[1:0], triggerSources[trigSelect]};
         if (trigSync[1] == trigSync[2])
            trigLevel <= trigSync[2];
         trigPrev <= trigLevel;
      end
   end

   wire logic trigRise = trigLevel && !trigPrev;
   // end address reached or hole in memory
   assign lastWord = (scanAddr == scanEnd) || !memRsp.implemented;
   assign scanLoad = (scanState == SCN_READ) && memRsp.valid;
   assign scanFinish = scanLoad && lastWord;

   // scanner sequencer; start address register kept apart from the live pointer
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         scanState <= SCN_IDLE;
         scanRun <= 1'b0;
         scanStart <= '0;
      end
      else if (wrAcc && isReg(paddr, OFF_SCAN_START))
         scanStart <= ADDR_W'(merge({17'h00000, scanStart}, pwdata, pstrb));
      else if (!enable)
      begin
         scanState <= SCN_IDLE;
         scanRun <= 1'b0;
      end
      else
      begin
         if (wrAcc && isReg(paddr, OFF_SCAN_CONTROL) && pstrb[0] && !pwdata[SC_RUN]
             && !(scanRun && scanMode == MODE_BURST))
         begin
            scanRun <= 1'b0;
            if (scanState != SCN_READ)
               scanState <= SCN_IDLE;
         end
         else if (wrAcc && isReg(paddr, OFF_SCAN_CONTROL) && pstrb[0] && pwdata[SC_RUN] && !scanRun)
         begin
            scanRun <= 1'b1;
            scanState <= SCN_WAIT;
         end
         unique case (scanState)
            SCN_IDLE:
               ;
            SCN_WAIT:
            begin
               // engine ready means run set and no word pending
               // peek only on cpu idle cycles
               if (scanRun && checksumRun && !full && !(scanPrio && cpuNeedsMemory && scanMode != MODE_BURST)
                   && (scanMode != MODE_PEEK || !cpuNeedsMemory)
                   && (scanMode != MODE_TRIGGERED || trigRise))
                  scanState <= SCN_READ;
            end
            SCN_READ:
            begin
               if (scanLoad)
               begin
                  if (lastWord)
                  begin
                     scanRun <= 1'b0;
                     scanState <= SCN_IDLE;
                  end
                  else
                     scanState <= scanRun ? SCN_WAIT : SCN_IDLE;
               end
            end
            default:
               scanState <= SCN_IDLE;
         endcase
      end
   end

   // live address pointer, loaded at scan start
   always_ff @(posedge clk)
   begin
      if (reset)
         scanAddr <= '0;
      else if (wrAcc && isReg(paddr, OFF_SCAN_CONTROL) && pstrb[0] && pwdata[SC_RUN] && !scanRun)
         scanAddr <= scanStart;
      // walk pointer up to end address
      else if (scanLoad)
         scanAddr <= scanAddr + ADDR_W'(1);
   end

   assign memReq.req = (scanState == SCN_READ);
   assign memReq.addr = scanAddr;
   // burst without prio stalls whole scan, peek never stalls, others only the access
   assign cpuStall = (scanState == SCN_READ && scanMode != MODE_PEEK)
                     || (scanRun && scanMode == MODE_BURST && !scanPrio);
   assign crcDoneIrq = crcDone && checksum_done_irq_enable;
   assign scanDoneIrq = scanDone && scan_done_irq_enable;

   // read mux, registered data out
   always_ff @(posedge clk)
   begin
      if (reset)
         prdata <= 32'h00000000;
      else if (rdAcc)
      begin
         unique case (paddr)
            OFF_CONTROL_0: prdata <= {24'h000000, enable, checksumRun, busy, augment, 2'b00, lsbFirst, full};
            OFF_CONTROL_1: prdata <= {24'h000000, polyWidthM2, dataWidthM1};
            OFF_INPUT_WORD: prdata <= {16'h0000, inputWord};
            OFF_ACCUMULATOR: prdata <= {16'h0000, accumulator};
            OFF_POLYNOMIAL: prdata <= {16'h0000, polynomial};
            OFF_SCAN_CONTROL: prdata <= {24'h000000, scanRun, 2'b00, scanPrio, 2'b00, scanMode};
            OFF_SCAN_START: prdata <= {17'h00000, scanStart};
            OFF_SCAN_END: prdata <= {17'h00000, scanEnd};
            OFF_SCAN_TRIGGER: prdata <= {28'h0000000, trigSelect};
            OFF_FLAGS: prdata <= {22'h000000, scan_done_irq_enable, checksum_done_irq_enable, 6'h00, scanDone, crcDone};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: test/crcs_properties.sv */
// Purpose: port-level checks
// Assumes: scan mode, run and irq enable mirrored from APB writes
// Notes: zero-wait APB, so a write lands at the access edge
`timescale 1ns/100ps
`default_nettype none
module crcs_properties
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire crcs_pkg::crcs_mem_req_t memReq,
   input wire crcs_pkg::crcs_mem_rsp_t memRsp,
   input wire logic cpuNeedsMemory,
   input wire logic [15:0] triggerSources,
   input wire logic cpuStall,
   input wire logic crcDoneIrq,
   input wire logic scanDoneIrq
);
   import crcs_pkg::*;
   logic wr;
   logic [1:0] mode;
   logic crcRun;
   logic checksum_done_irq_enable;
   logic haveLast;
   logic [ADDR_W-1:0] lastAddr;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // a write takes effect at the access edge
   assign wr = psel && penable && pwrite && pready;
   // software view of mode, run and enable
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mode <= 2'b00;
         crcRun <= 1'b0;
         checksum_done_irq_enable <= 1'b0;
      end
      else if (wr && paddr == OFF_SCAN_CONTROL)
         mode <= pwdata[1:0];
      else if (wr && paddr == OFF_CONTROL_0)
         crcRun <= pwdata[C0_ENABLE] && pwdata[C0_RUN];
      else if (wr && paddr == OFF_FLAGS)
         checksum_done_irq_enable <= pwdata[FL_CRC_IE];
   end
   // last answered address, forgotten when a new scan is set up
   always_ff @(posedge clk)
   begin
      if (reset || (wr && paddr != OFF_FLAGS))
         haveLast <= 1'b0;
      else if (memRsp.valid && memReq.req)
         haveLast <= 1'b1;
      if (memRsp.valid && memReq.req)
         lastAddr <= memReq.addr;
   end
   chk_done_sticky: assert property (crcDoneIrq && !(wr && (paddr == OFF_FLAGS || paddr == OFF_CONTROL_0))
      |=> crcDoneIrq) else $error("checksum done dropped without software");
   chk_scan_sticky: assert property (scanDoneIrq && !(wr && (paddr == OFF_FLAGS || paddr == OFF_CONTROL_0))
      |=> scanDoneIrq) else $error("scan done dropped without software");
   chk_irq_gate: assert property (crcDoneIrq |-> checksum_done_irq_enable) else $error("checksum irq without enable");
   chk_peek_quiet: assert property (mode == MODE_PEEK && $past(mode) == MODE_PEEK |-> !cpuStall)
      else $error("cpu stalled in peek mode");
   chk_fetch_stalls: assert property (memReq.req && mode != MODE_PEEK && $stable(mode) |-> cpuStall)
      else $error("fetch without cpu stall");
   chk_stall_access: assert property ((mode == MODE_CONCURRENT || mode == MODE_TRIGGERED) && cpuStall
      |-> memReq.req || $past(memReq.req)) else $error("stall outside an access");
   chk_wait_ready: assert property (!crcRun && !$past(crcRun) |-> !$rose(memReq.req))
      else $error("fetch while engine not running");
   chk_req_holds: assert property (memReq.req && !memRsp.valid && !wr |=> memReq.req && $stable(memReq.addr))
      else $error("fetch request changed before answer");
   chk_addr_step: assert property ($rose(memReq.req) && haveLast |-> memReq.addr == lastAddr + 15'h0001)
      else $error("scan address not ascending by one");
endmodule
`default_nettype wire

/* File: test/crcs_mem_model.sv */
// Purpose: program memory answering scanner fetches
// Assumes: one outstanding fetch, answered by a one-cycle valid
// Notes: data is a function of address
`timescale 1ns/100ps
`default_nettype none
module crcs_mem_model
#(
   parameter logic [14:0] IMPL_LIMIT = 15'h0100
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire crcs_pkg::crcs_mem_req_t memReq,
   output crcs_pkg::crcs_mem_rsp_t memRsp
);
   import crcs_pkg::*;
   logic busyM;
   int waitCnt;
   // fetch answer; idle data inverts so stale words never look valid
   always_ff @(posedge clk)
   begin
      memRsp.valid <= 1'b0;
      memRsp.data <= ~memRsp.data;
      if (reset)
      begin
         busyM <= 1'b0;
         memRsp.data <= 16'h0000;
         memRsp.implemented <= 1'b0;
      end
      else if (busyM && !memReq.req)
         busyM <= 1'b0;
      else if (busyM && waitCnt == 0)
      begin
         memRsp.valid <= 1'b1;
         // addresses at or past the limit are unimplemented
         memRsp.implemented <= memReq.addr < IMPL_LIMIT;
         memRsp.data <= {1'b0, memReq.addr} ^ 16'hC3A5;
         busyM <= 1'b0;
      end
      else if (busyM)
         waitCnt <= waitCnt - 1;
      else if (memReq.req && !memRsp.valid)
      begin
         busyM <= 1'b1;
         waitCnt <= slow ? int'($urandom_range(4, 1)) : 0;
      end
   end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench
// Assumes: read data taken at the access edge
// Notes: cpu memory use is random; triggers pulse every 16 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import crcs_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0] pstrb, trigCnt;
   crcs_mem_req_t memReq;
   crcs_mem_rsp_t memRsp;
   logic cpuNeedsMemory, cpuStall, crcDoneIrq, scanDoneIrq, slow, aug, lsb;
   logic [15:0] triggerSources, trigMask, seed, poly, exp;
   logic [14:0] fetched[$];
   int fail_count, checked, pl, dl, s, e, n;
   crcs_top crcs_top_inst (.*);
   crcs_mem_model crcs_mem_model_inst (.clk(clk), .reset(reset), .slow(slow), .memReq(memReq), .memRsp(memRsp));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // cpu memory use, trigger pulses and a log of answered fetches
   always @(posedge clk)
   begin
      cpuNeedsMemory <= 1'($urandom_range(1, 0));
      trigCnt <= trigCnt + 4'h1;
      triggerSources <= trigCnt[3] ? trigMask : 16'h0000;
      if (memRsp.valid === 1'b1 && memReq.req === 1'b1)
         fetched.push_back(memReq.addr);
   end
   task automatic check(input logic [31:0] got, input logic [31:0] want, input string msg);
      checked++;
      if (got !== want)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, want);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one APB transfer; read data taken at the access edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         k++;
         if (k > 50)
         begin
            check(32'h0, 32'h1, "no pready");
            complete_run();
         end
         @(posedge clk);
      end
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitreg(input logic [7:0] a, input int b, input logic v);
      for (int k = 0; k < 400; k++)
      begin
         apb(1'b0, a, 32'h0);
         if (rdv[b] === v)
            return;
      end
      check(32'h0, 32'h1, "wait expired");
      complete_run();
   endtask
   task automatic feed(input logic [15:0] w);
      waitreg(OFF_CONTROL_0, C0_FULL, 1'b0);
      apb(1'b1, OFF_INPUT_WORD, {16'h0000, w});
   endtask
   // reference shifter: data enters the bottom, top bit feeds back
   function automatic logic [15:0] crc(input logic [15:0] acc, input logic [15:0] p, input int pw, input int dw,
      input logic lf, input logic [15:0] w);
      logic [16:0] m;
      logic top;
      m = (17'h00001 << (pw + 1)) - 17'h00001;
      acc = acc & m[15:0];
      for (int i = 0; i <= dw; i++)
      begin
         top = acc[pw];
         acc = ((acc << 1) | 16'(lf ? w[i] : w[dw - i])) & m[15:0];
         if (top)
            acc = acc ^ ((p | 16'h0001) & m[15:0]);
      end
      return acc;
   endfunction
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, slow, trigCnt, triggerSources, trigMask} = '0;
      pstrb = 4'hF;
      cpuNeedsMemory = 1'b0;
      fail_count = 0;
      checked = 0;
      void'($urandom(32'hFE01));
      reset = 1'b1;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      apb(1'b1, 8'hF0, 32'hFFFFFFFF);
      apb(1'b0, 8'hF0, 32'h0);
      check(rdv, 32'h0, "unmapped read");
      // worked example, zeros entered by hand, both bit orders
      for (int o = 0; o < 2; o++)
      begin
         apb(1'b1, OFF_CONTROL_0, 32'h80);
         apb(1'b1, OFF_ACCUMULATOR, 32'h0);
         apb(1'b1, OFF_POLYNOMIAL, 32'h8004);
         apb(1'b1, OFF_CONTROL_1, 32'hE7);
         apb(1'b1, OFF_INPUT_WORD, 32'hFF55);
         repeat (20) @(posedge clk);
         apb(1'b0, OFF_ACCUMULATOR, 32'h0);
         check(rdv, 32'h0, "shifted while run clear");
         apb(1'b1, OFF_CONTROL_0, 32'hC0 | (o << 1));
         feed(16'h0066);
         feed(16'h0077);
         feed(16'h0088);
         feed(16'h0000);
         feed(16'h0000);
         apb(1'b0, OFF_CONTROL_0, 32'h0);
         check(rdv[C0_BUSY], 1'b1, "busy while shifting");
         waitreg(OFF_CONTROL_0, C0_BUSY, 1'b0);
         apb(1'b0, OFF_ACCUMULATOR, 32'h0);
         check(rdv[15:0], (o == 1) ? 16'h6BA2 : 16'h32D6, "example check value");
      end
      // random widths, seeds, orders and augment
      for (int t = 0; t < 8; t++)
      begin
         seed = 16'($urandom);
         poly = 16'($urandom);
         pl = $urandom_range(14, 2);
         dl = $urandom_range(15, 9);
         aug = 1'($urandom_range(1, 0));
         lsb = 1'($urandom_range(1, 0));
         exp = crc(seed, poly, pl + 1, -1, 1'b0, 16'h0);
         apb(1'b1, OFF_CONTROL_0, 32'h80);
         apb(1'b1, OFF_FLAGS, 32'h101);
         apb(1'b1, OFF_ACCUMULATOR, {16'h0000, seed});
         apb(1'b1, OFF_POLYNOMIAL, {16'h0000, poly});
         apb(1'b1, OFF_CONTROL_1, 32'((pl << 4) | dl));
         apb(1'b1, OFF_CONTROL_0, {24'h0, 2'b11, 1'b0, aug, 2'b00, lsb, 1'b0});
         for (int k = 0; k < 3; k++)
         begin
            seed = 16'($urandom);
            feed(seed);
            exp = crc(exp, poly, pl + 1, dl, lsb, seed);
         end
         if (aug)
            exp = crc(exp, poly, pl + 1, pl + 1, 1'b0, 16'h0);
         waitreg(OFF_CONTROL_0, C0_BUSY, 1'b0);
         apb(1'b0, OFF_ACCUMULATOR, 32'h0);
         check(rdv[15:0], exp, "random check value");
         repeat (10) @(posedge clk);
         check(crcDoneIrq, 1'b1, "done flag after busy fell");
         apb(1'b1, OFF_FLAGS, 32'h001);
         check(crcDoneIrq, 1'b0, "done flag cleared");
      end
      // every scan mode; engine held off first, wrong trigger source first
      apb(1'b1, OFF_CONTROL_1, 32'hEF);
      apb(1'b1, OFF_POLYNOMIAL, 32'h1021);
      apb(1'b1, OFF_SCAN_TRIGGER, 32'h5);
      for (int m = 0; m < 4; m++)
      begin
         slow <= m[0];
         trigMask <= 16'h0001;
         s = $urandom_range(200, 0);
         e = s + $urandom_range(6, 2);
         apb(1'b1, OFF_CONTROL_0, 32'h80);
         apb(1'b1, OFF_ACCUMULATOR, 32'hFFFF);
         apb(1'b1, OFF_FLAGS, 32'h203);
         apb(1'b1, OFF_SCAN_START, 32'(s));
         apb(1'b1, OFF_SCAN_END, 32'(e));
         fetched.delete();
         apb(1'b1, OFF_SCAN_CONTROL, 32'(32'h80 | m));
         repeat (40) @(posedge clk);
         check(32'(fetched.size()), 32'h0, "fetch before engine ready");
         apb(1'b1, OFF_CONTROL_0, 32'hD0);
         if (m == 1)
            check(cpuStall, 1'b1, "burst stall");
         if (m == 3)
         begin
            repeat (60) @(posedge clk);
            check(32'(fetched.size()), 32'h0, "fetch on unselected trigger");
            trigMask <= 16'h0020;
         end
         waitreg(OFF_SCAN_CONTROL, SC_RUN, 1'b0);
         check(scanDoneIrq, 1'b1, "scan done flag");
         waitreg(OFF_CONTROL_0, C0_BUSY, 1'b0);
         exp = 16'hFFFF;
         for (int a = s; a <= e; a++)
            exp = crc(exp, 16'h1021, 15, 15, 1'b0, 16'(a) ^ 16'hC3A5);
         exp = crc(exp, 16'h1021, 15, 15, 1'b0, 16'h0);
         apb(1'b0, OFF_ACCUMULATOR, 32'h0);
         check(rdv[15:0], exp, "scan check value");
         check(32'(fetched.size()), 32'(e - s + 1), "scan word count");
         check(32'(fetched[0]), 32'(s), "scan first address");
      end
      // unimplemented address ends a concurrent scan
      fetched.delete();
      apb(1'b1, OFF_SCAN_START, 32'hFC);
      apb(1'b1, OFF_SCAN_END, 32'h200);
      apb(1'b1, OFF_SCAN_CONTROL, 32'h80);
      waitreg(OFF_SCAN_CONTROL, SC_RUN, 1'b0);
      check(32'(fetched.size()), 32'h5, "stop at unimplemented");
      // software stop, then disable with scan running
      for (int q = 0; q < 2; q++)
      begin
         apb(1'b1, OFF_CONTROL_0, 32'hC0);
         apb(1'b1, OFF_SCAN_START, 32'h0);
         apb(1'b1, OFF_SCAN_END, 32'h40);
         apb(1'b1, OFF_SCAN_CONTROL, 32'h80);
         repeat (30) @(posedge clk);
         apb(1'b1, (q == 0) ? OFF_SCAN_CONTROL : OFF_CONTROL_0, 32'h0);
         repeat (20) @(posedge clk);
         n = fetched.size();
         repeat (60) @(posedge clk);
         check(32'(fetched.size()), 32'(n), "fetching after stop");
      end
      apb(1'b0, OFF_SCAN_END, 32'h0);
      check(rdv, 32'h40, "end address kept");
      complete_run();
   end
   initial
   begin
      #380000;
      check(32'h0, 32'h1, "run too long");
      complete_run();
   end
endmodule
bind crcs_top crcs_properties crcs_properties_inst (.*);
`default_nettype wire
